/* File: rfsb_defines.svh */
// Purpose: constants of the front-end, time-stamp and buffer-empty pin block
// Assumes: core clock of 100 MHz
// Notes: register offsets are the byte addresses of the 8-bit register port
`ifndef RFSB_DEFINES_SVH
`define RFSB_DEFINES_SVH

`define RFSB_ADDR_W 6
`define RFSB_DATA_W 8

// register offsets
`define RFSB_TRX_CTRL_ONE_ADDR 6'h04
`define RFSB_EXT_MODE_CTRL_ONE_ADDR 6'h17

// reset values
`define RFSB_TRX_CTRL_ONE_RST 8'h22
`define RFSB_EXT_MODE_CTRL_ONE_RST 8'h00
// writable bits of the extended mode register (bit 3 reads zero)
`define RFSB_EXT_MODE_WR_MASK 8'hf7

// field positions in transceiver_control_one
`define RFSB_FRONT_END_CTRL_ENABLE_BIT 7
`define RFSB_STAMP_PIN_ENABLE_BIT 6
`define RFSB_BUFFER_EMPTY_FLAG_ENABLE_BIT 4
// field position in extended_mode_control_one
`define RFSB_RETRY_TX_STAMP_ENABLE_BIT 7

// timing
`define RFSB_CLK_PERIOD_NS 10
`define RFSB_TX_ON_DELAY_NS 6000
`define RFSB_TX_OFF_DELAY_NS 3000
`define RFSB_TX_ON_CYC ((`RFSB_TX_ON_DELAY_NS + `RFSB_CLK_PERIOD_NS - 1) / `RFSB_CLK_PERIOD_NS)
`define RFSB_TX_OFF_CYC ((`RFSB_TX_OFF_DELAY_NS + `RFSB_CLK_PERIOD_NS - 1) / `RFSB_CLK_PERIOD_NS)
`define RFSB_DLY_CNT_W 10

`endif

/* File: rfsb_pkg.sv */
// Purpose: types of the front-end, time-stamp and buffer-empty pin block
// Assumes: nothing
// Notes: constants live in rfsb_defines.svh
package rfsb_pkg;

  typedef enum logic [1:0] {
    FE_IDLE,
    FE_WAIT_ON,
    FE_TX,
    FE_WAIT_OFF
  } rfsb_fe_state_t;

endpackage : rfsb_pkg

/* File: rfsb_fbe_if.sv */
// Purpose: signals between the pin block and its buffer-empty tracker
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface rfsb_fbe_if #(parameter int CNT_W = 8);
  logic enable;
  logic cmd_done;
  logic sel_n;
  logic byte_read;
  logic rx_error;
  logic [CNT_W-1:0] wr_count;
  logic active;
  logic empty;

  modport core (output enable, output cmd_done, output sel_n, output byte_read, output rx_error,
                output wr_count, input active, input empty);
  modport fbe (input enable, input cmd_done, input sel_n, input byte_read, input rx_error,
               input wr_count, output active, output empty);
endinterface : rfsb_fbe_if

/* File: rfsb_fbe.sv */
// Purpose: tracks a frame buffer read and tells when the next byte is missing
// Assumes: byte_read pulses once per payload byte taken by the host
// Notes: appended status bytes are not counted in wr_count
`timescale 1ns/1ps
module rfsb_fbe #(
  parameter int CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  rfsb_fbe_if.fbe fbe
);

  logic active_q;
  logic active_d;
  logic lock_q;
  logic lock_d;
  logic [CNT_W-1:0] rd_q;
  logic [CNT_W-1:0] rd_d;
  wire logic start_w;
  wire logic caught_up_w;

  initial begin
    if (CNT_W < 1) begin
      $error("rfsb_fbe: CNT_W must be at least 1");
    end
  end

  // indicator starts at the end of the read command, only while enabled
  assign start_w = fbe.enable && fbe.cmd_done && !fbe.sel_n;
  assign caught_up_w = (rd_q >= fbe.wr_count);

  always_comb begin
    active_d = active_q;
    if (fbe.sel_n) begin
      active_d = 1'b0;
    end else if (start_w) begin
      active_d = 1'b1;
    end
  end

  always_comb begin
    lock_d = lock_q;
    if (fbe.sel_n || start_w) begin
      lock_d = 1'b0;
    end else if (active_q && fbe.rx_error) begin
      lock_d = 1'b1;
    end
  end

  always_comb begin
    rd_d = rd_q;
    if (start_w) begin
      rd_d = '0;
    end else if (active_q && fbe.byte_read && !caught_up_w) begin
      rd_d = rd_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_q <= 1'b0;
      lock_q <= 1'b0;
      rd_q <= '0;
    end else begin
      active_q <= active_d;
      lock_q <= lock_d;
      rd_q <= rd_d;
    end
  end

  assign fbe.active = active_q;
  assign fbe.empty = lock_q || caught_up_w;

  AST_FBE_LOCK: assert property (@(posedge clk_in) disable iff (rst_in)
    (active_q && fbe.rx_error && !fbe.sel_n && !start_w) |=> fbe.empty)
    else $error("buffer-empty indicator did not lock after receive error");

  AST_FBE_LOCK_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (lock_q && !fbe.sel_n && !start_w) |=> lock_q)
    else $error("buffer-empty lock released while chip select low");

  AST_FBE_END: assert property (@(posedge clk_in) disable iff (rst_in)
    (active_q && fbe.sel_n) |=> !active_q)
    else $error("indicator still active after chip select rose");

  AST_FBE_START: assert property (@(posedge clk_in) disable iff (rst_in)
    (!active_q && fbe.cmd_done && !fbe.sel_n) |=> (active_q == $past(fbe.enable)))
    else $error("indicator start does not follow enable bit");

endmodule // rfsb_fbe

/* File: rfsb_pins.sv */
// Purpose: front-end control pair, time-stamp pin and interrupt pin sharing
// Assumes: event inputs are one-cycle pulses synchronous to REF_CLK_IN
// Notes: pin outputs are registered and follow register writes one edge later
`timescale 1ns/1ps
`include "rfsb_defines.svh"
module rfsb_pins #(
  parameter int CNT_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [`RFSB_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [`RFSB_DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  output logic [`RFSB_DATA_W-1:0] REG_RDATA_OUT,
  input wire logic TX_REQ_IN,
  input wire logic PA_OFF_IN,
  input wire logic PHR_VALID_IN,
  input wire logic TX_FRAME_START_IN,
  input wire logic FRAME_END_IN,
  input wire logic AUTO_RETRY_TRANSMIT_MODE_IN,
  input wire logic RX_START_MASK_IN,
  input wire logic ANT_SW_EN_IN,
  input wire logic ANT_SW_LEVEL_IN,
  input wire logic CORE_IRQ_IN,
  input wire logic FB_READ_CMD_DONE_IN,
  input wire logic SEL_N_IN,
  input wire logic FB_BYTE_READ_IN,
  input wire logic [CNT_W-1:0] FB_WR_COUNT_IN,
  input wire logic RX_ERROR_IN,
  output logic FRONT_END_CTRL_POS_OUT,
  output logic FRONT_END_CTRL_NEG_OUT,
  output logic TIME_STAMP_PIN_OUT,
  output logic IRQ_PIN_OUT
);

  localparam int TX_ON_CYC = `RFSB_TX_ON_CYC;
  localparam int TX_OFF_CYC = `RFSB_TX_OFF_CYC;

  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("rfsb_pins: CNT_W out of range");
    end
    if (TX_ON_CYC < 1 || TX_ON_CYC >= (1 << `RFSB_DLY_CNT_W)) begin
      $error("rfsb_pins: transmit-on delay does not fit the counter");
    end
    if (TX_OFF_CYC < 1 || TX_OFF_CYC >= (1 << `RFSB_DLY_CNT_W)) begin
      $error("rfsb_pins: transmit-off delay does not fit the counter");
    end
  end

  // registers
  logic [`RFSB_DATA_W-1:0] ctrl_one_q;
  logic [`RFSB_DATA_W-1:0] ext_mode_q;
  logic [`RFSB_DATA_W-1:0] rdata_q;
  wire logic wr_ctrl_w;
  wire logic wr_ext_w;
  wire logic [`RFSB_DATA_W-1:0] rdata_d;
  wire logic front_end_ctrl_enable;
  wire logic stamp_pin_enable;
  wire logic buffer_empty_flag_enable;
  wire logic retry_tx_stamp_enable;

  assign wr_ctrl_w = REG_WR_IN && (REG_ADDR_IN == `RFSB_TRX_CTRL_ONE_ADDR);
  assign wr_ext_w = REG_WR_IN && (REG_ADDR_IN == `RFSB_EXT_MODE_CTRL_ONE_ADDR);
  assign rdata_d = (REG_ADDR_IN == `RFSB_TRX_CTRL_ONE_ADDR) ? ctrl_one_q :
                   (REG_ADDR_IN == `RFSB_EXT_MODE_CTRL_ONE_ADDR) ? ext_mode_q : 8'h00;

  assign front_end_ctrl_enable = ctrl_one_q[`RFSB_FRONT_END_CTRL_ENABLE_BIT];
  assign stamp_pin_enable = ctrl_one_q[`RFSB_STAMP_PIN_ENABLE_BIT];
  assign buffer_empty_flag_enable = ctrl_one_q[`RFSB_BUFFER_EMPTY_FLAG_ENABLE_BIT];
  assign retry_tx_stamp_enable = ext_mode_q[`RFSB_RETRY_TX_STAMP_ENABLE_BIT];

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_one_q <= `RFSB_TRX_CTRL_ONE_RST;
      ext_mode_q <= `RFSB_EXT_MODE_CTRL_ONE_RST;
      rdata_q <= 8'h00;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_one_q <= REG_WDATA_IN;
      end
      if (wr_ext_w) begin
        ext_mode_q <= REG_WDATA_IN & `RFSB_EXT_MODE_WR_MASK;
      end
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_OUT = rdata_q;

  // transmit indication sequencer
  rfsb_pkg::rfsb_fe_state_t fe_st_q;
  rfsb_pkg::rfsb_fe_state_t fe_st_d;
  logic [`RFSB_DLY_CNT_W-1:0] dly_q;
  logic [`RFSB_DLY_CNT_W-1:0] dly_d;
  logic tx_ind_q;
  wire logic tx_ind_d;

  always_comb begin
    fe_st_d = fe_st_q;
    dly_d = dly_q;
    unique case (fe_st_q)
      rfsb_pkg::FE_IDLE: begin
        if (TX_REQ_IN) begin
          fe_st_d = rfsb_pkg::FE_WAIT_ON;
          dly_d = `RFSB_DLY_CNT_W'(TX_ON_CYC - 1);
        end
      end
      rfsb_pkg::FE_WAIT_ON: begin
        if (dly_q == '0) begin
          fe_st_d = rfsb_pkg::FE_TX;
        end else begin
          dly_d = dly_q - `RFSB_DLY_CNT_W'(1);
        end
      end
      rfsb_pkg::FE_TX: begin
        if (PA_OFF_IN) begin
          fe_st_d = rfsb_pkg::FE_WAIT_OFF;
          dly_d = `RFSB_DLY_CNT_W'(TX_OFF_CYC - 1);
        end
      end
      rfsb_pkg::FE_WAIT_OFF: begin
        if (dly_q == '0) begin
          fe_st_d = rfsb_pkg::FE_IDLE;
        end else begin
          dly_d = dly_q - `RFSB_DLY_CNT_W'(1);
        end
      end
    endcase
  end

  assign tx_ind_d = (fe_st_d == rfsb_pkg::FE_TX) || (fe_st_d == rfsb_pkg::FE_WAIT_OFF);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fe_st_q <= rfsb_pkg::FE_IDLE;
      dly_q <= '0;
      tx_ind_q <= 1'b0;
    end else begin
      fe_st_q <= fe_st_d;
      dly_q <= dly_d;
      tx_ind_q <= tx_ind_d;
    end
  end

  // front-end pair, registered from current enable (one-edge latency)
  wire logic fe_pos_d;
  wire logic fe_neg_d;
  logic fe_pos_q;
  logic fe_neg_q;

  assign fe_pos_d = front_end_ctrl_enable && tx_ind_q;
  assign fe_neg_d = front_end_ctrl_enable && !tx_ind_q;

  // time stamp flag
  wire logic stamp_en_w;
  wire logic stamp_set_w;
  logic stamp_q;
  logic stamp_pin_q;
  wire logic stamp_pin_d;

  assign stamp_en_w = stamp_pin_enable || !RX_START_MASK_IN;
  // receive stamping in every mode, transmit stamping only in retry mode
  assign stamp_set_w = stamp_en_w && (PHR_VALID_IN ||
    (TX_FRAME_START_IN && AUTO_RETRY_TRANSMIT_MODE_IN && retry_tx_stamp_enable));
  // antenna switch level overrides, otherwise ground when stamping is off
  assign stamp_pin_d = ANT_SW_EN_IN ? ANT_SW_LEVEL_IN : (stamp_en_w && stamp_q);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stamp_q <= 1'b0;
    end else if (stamp_set_w) begin
      stamp_q <= 1'b1;
    end else if (FRAME_END_IN) begin
      stamp_q <= 1'b0;
    end
  end

  // buffer-empty tracker
  rfsb_fbe_if #(.CNT_W(CNT_W)) fbe_bus ();
  logic irq_pin_q;
  wire logic irq_pin_d;

  assign fbe_bus.enable = buffer_empty_flag_enable;
  assign fbe_bus.cmd_done = FB_READ_CMD_DONE_IN;
  assign fbe_bus.sel_n = SEL_N_IN;
  assign fbe_bus.byte_read = FB_BYTE_READ_IN;
  assign fbe_bus.rx_error = RX_ERROR_IN;
  assign fbe_bus.wr_count = FB_WR_COUNT_IN;

  rfsb_fbe #(.CNT_W(CNT_W)) u_fbe (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .fbe(fbe_bus)
  );

  assign irq_pin_d = fbe_bus.active ? fbe_bus.empty : CORE_IRQ_IN;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fe_pos_q <= 1'b0;
      fe_neg_q <= 1'b0;
      stamp_pin_q <= 1'b0;
      irq_pin_q <= 1'b0;
    end else begin
      fe_pos_q <= fe_pos_d;
      fe_neg_q <= fe_neg_d;
      stamp_pin_q <= stamp_pin_d;
      irq_pin_q <= irq_pin_d;
    end
  end

  assign FRONT_END_CTRL_POS_OUT = fe_pos_q;
  assign FRONT_END_CTRL_NEG_OUT = fe_neg_q;
  assign TIME_STAMP_PIN_OUT = stamp_pin_q;
  assign IRQ_PIN_OUT = irq_pin_q;

  // checks
  AST_FE_OFF: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !front_end_ctrl_enable |=> (!FRONT_END_CTRL_POS_OUT && !FRONT_END_CTRL_NEG_OUT))
    else $error("front-end outputs not low while disabled");

  AST_FE_PAIR: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    front_end_ctrl_enable |=> (FRONT_END_CTRL_POS_OUT == $past(tx_ind_q)) &&
      (FRONT_END_CTRL_NEG_OUT != FRONT_END_CTRL_POS_OUT))
    else $error("front-end pair does not follow transmit indication");

  AST_TX_ON_LOAD: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (fe_st_q == rfsb_pkg::FE_IDLE && TX_REQ_IN) |=>
      (fe_st_q == rfsb_pkg::FE_WAIT_ON && dly_q == `RFSB_DLY_CNT_W'(TX_ON_CYC - 1) && !tx_ind_q))
    else $error("transmit-on delay not started correctly");

  AST_TX_ON_END: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (fe_st_q == rfsb_pkg::FE_WAIT_ON && dly_q == '0) |=> tx_ind_q ##1 tx_ind_q)
    else $error("transmit indication not raised at end of delay");

  AST_TX_OFF: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (fe_st_q == rfsb_pkg::FE_TX && PA_OFF_IN) |=>
      (tx_ind_q && dly_q == `RFSB_DLY_CNT_W'(TX_OFF_CYC - 1)))
    else $error("transmit-off delay not started correctly");

  AST_STAMP_SET: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (stamp_en_w && PHR_VALID_IN) |=> stamp_q ##1 (TIME_STAMP_PIN_OUT || $past(ANT_SW_EN_IN) || !$past(stamp_en_w)))
    else $error("time stamp not raised on header reception");

  AST_STAMP_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (stamp_q && !FRAME_END_IN) |=> stamp_q)
    else $error("time stamp dropped before frame end");

  AST_STAMP_TX_MODE: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (!stamp_q && TX_FRAME_START_IN && !AUTO_RETRY_TRANSMIT_MODE_IN && !PHR_VALID_IN) |=> !stamp_q)
    else $error("transmit stamp outside retry mode");

  AST_STAMP_RETRY: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (TX_FRAME_START_IN && AUTO_RETRY_TRANSMIT_MODE_IN && retry_tx_stamp_enable && stamp_en_w) |=> stamp_q)
    else $error("retry-mode transmission not stamped");

  AST_STAMP_GND: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (!ANT_SW_EN_IN && !stamp_pin_enable && RX_START_MASK_IN) |=> !TIME_STAMP_PIN_OUT)
    else $error("unused time-stamp pin not grounded");

  AST_IRQ_EMPTY: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (fbe_bus.active && fbe_bus.empty) |=> IRQ_PIN_OUT)
    else $error("interrupt pin low while buffer empty");

  AST_IRQ_PASS: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !fbe_bus.active |=> (IRQ_PIN_OUT == $past(CORE_IRQ_IN)))
    else $error("interrupt pin not showing interrupts outside buffer read");

  AST_TX_OFF_END: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (fe_st_q == rfsb_pkg::FE_WAIT_OFF && dly_q == '0) |=> (!tx_ind_q && fe_st_q == rfsb_pkg::FE_IDLE))
    else $error("transmit indication not dropped at end of off delay");

  AST_STAMP_SET_WINS: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    stamp_set_w |=> stamp_q)
    else $error("time stamp not set on a qualified event");

  AST_STAMP_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (stamp_q && FRAME_END_IN && !stamp_set_w) |=> !stamp_q)
    else $error("time stamp not cleared at frame end");

  AST_FE_ENABLE_LAG: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    $rose(front_end_ctrl_enable) |=> (FRONT_END_CTRL_POS_OUT || FRONT_END_CTRL_NEG_OUT))
    else $error("front-end pair did not follow enable write in time");

endmodule // rfsb_pins

/* File: rfsb_host_model.sv */
// Purpose: host side of a frame buffer read, reading only while the indicator is low
// Assumes: drives its outputs at the falling clock edge
// Notes: hold_in keeps chip select low after the last byte
`timescale 1ns/1ps
module rfsb_host_model (
  input wire logic clk_in,
  input wire logic irq_in,
  input wire logic go_in,
  input wire logic [7:0] nbytes_in,
  input wire logic hold_in,
  output logic sel_n_out,
  output logic cmd_done_out,
  output logic byte_read_out,
  output logic [7:0] got_out,
  output logic busy_out
);
  initial begin
    sel_n_out = 1'h1;
    cmd_done_out = 1'h0;
    byte_read_out = 1'h0;
    got_out = 8'h00;
    busy_out = 1'h0;
    forever begin
      @(posedge clk_in);
      if (go_in && !busy_out) begin
        @(negedge clk_in);
        busy_out = 1'h1;
        got_out = 8'h00;
        sel_n_out = 1'h0;
        @(negedge clk_in);
        cmd_done_out = 1'h1;
        @(negedge clk_in);
        cmd_done_out = 1'h0;
        repeat (2) @(negedge clk_in);
        while (got_out < nbytes_in) begin
          if (irq_in === 1'h0) begin
            byte_read_out = 1'h1;
            @(negedge clk_in);
            byte_read_out = 1'h0;
            got_out = got_out + 8'h01;
            repeat (2) @(negedge clk_in);
          end else begin
            @(negedge clk_in);
          end
        end
        while (hold_in) @(negedge clk_in);
        sel_n_out = 1'h1;
        busy_out = 1'h0;
      end
    end
  end
endmodule // rfsb_host_model

/* File: tb.sv */
// Purpose: self-checking bench of the front-end, time-stamp and buffer-empty pins
// Assumes: inputs change at the falling edge
// Notes: table rows cover time-stamp qualification, hand tests cover timing and the indicator
`timescale 1ns/1ps
`include "rfsb_defines.svh"
module tb;
  typedef struct {logic [7:0] ctrl; logic [7:0] ext; logic [5:0] f;} rfsb_row_t;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, txq = 1'h0, paoff = 1'h0, phr = 1'h0, txs = 1'h0, fend = 1'h0;
  logic aret = 1'h0, mask = 1'h1, ant = 1'h0, antl = 1'h0, cirq = 1'h0, rxe = 1'h0, go = 1'h0, hold = 1'h0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wd = 8'h00, cnt = 8'h00, nb = 8'h00, got, rd;
  logic sel_n, cmd, br, busy, pos, neg, stamp, irq;
  int failures = 0, n_tests = 0;
  // flags: retry mode, mask, antenna owns, antenna level, transmit event, expected stamp
  rfsb_row_t rows [9] = '{
    '{8'h00, 8'h00, 6'h10},
    '{8'h40, 8'h00, 6'h11},
    '{8'h00, 8'h00, 6'h01},
    '{8'hc0, 8'h80, 6'h33},
    '{8'h40, 8'h80, 6'h12},
    '{8'h40, 8'h00, 6'h32},
    '{8'h00, 8'h80, 6'h32},
    '{8'h00, 8'h00, 6'h1d},
    '{8'h40, 8'h00, 6'h18}
  };
  always #5 clk = ~clk;
  rfsb_pins #(.CNT_W(8)) dut (.REF_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
    .REG_WR_IN(wr), .REG_RDATA_OUT(rd), .TX_REQ_IN(txq), .PA_OFF_IN(paoff), .PHR_VALID_IN(phr),
    .TX_FRAME_START_IN(txs), .FRAME_END_IN(fend), .AUTO_RETRY_TRANSMIT_MODE_IN(aret), .RX_START_MASK_IN(mask),
    .ANT_SW_EN_IN(ant), .ANT_SW_LEVEL_IN(antl), .CORE_IRQ_IN(cirq), .FB_READ_CMD_DONE_IN(cmd), .SEL_N_IN(sel_n),
    .FB_BYTE_READ_IN(br), .FB_WR_COUNT_IN(cnt), .RX_ERROR_IN(rxe), .FRONT_END_CTRL_POS_OUT(pos),
    .FRONT_END_CTRL_NEG_OUT(neg), .TIME_STAMP_PIN_OUT(stamp), .IRQ_PIN_OUT(irq));
  rfsb_host_model host (.clk_in(clk), .irq_in(irq), .go_in(go), .nbytes_in(nb), .hold_in(hold),
    .sel_n_out(sel_n), .cmd_done_out(cmd), .byte_read_out(br), .got_out(got), .busy_out(busy));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'h1;
    cyc(1);
    wr = 1'h0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task automatic wait_for(ref logic s, input logic v, input string nm);
    int i;
    for (i = 0; i < 2000 && s !== v; i++) cyc(1);
    chk(nm, {7'h00, v}, {7'h00, s});
  endtask
  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic read_go(input logic [7:0] c, input logic [7:0] n, input logic h);
    cnt = c;
    nb = n;
    hold = h;
    go = 1'h1;
    wait_for(busy, 1'h1, "read start");
    go = 1'h0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("BAD watchdog expected end seen timeout");
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    chk("pins after reset", 8'h00, {4'h0, pos, neg, stamp, irq});
    addr = `RFSB_TRX_CTRL_ONE_ADDR;
    cyc(1);
    chk("control reset", 8'h22, rd);
    addr = `RFSB_EXT_MODE_CTRL_ONE_ADDR;
    cyc(1);
    chk("extended reset", 8'h00, rd);
    wreg(`RFSB_EXT_MODE_CTRL_ONE_ADDR, 8'hff);
    cyc(1);
    chk("extended readback", 8'hf7, rd);
    addr = 6'h05;
    cyc(1);
    chk("unmapped read", 8'h00, rd);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      wreg(`RFSB_TRX_CTRL_ONE_ADDR, rows[i].ctrl);
      cyc(1);
      wreg(`RFSB_EXT_MODE_CTRL_ONE_ADDR, rows[i].ext);
      {aret, mask, ant, antl} = rows[i].f[5:2];
      if (rows[i].f[1]) pulse(txs);
      else pulse(phr);
      cyc(1);
      chk("stamp", {7'h00, rows[i].f[0]}, {7'h00, stamp});
      chk("pair idle", {6'h00, 1'h0, rows[i].ctrl[7]}, {6'h00, pos, neg});
      pulse(fend);
      cyc(1);
      chk("stamp after end", {7'h00, ant & antl}, {7'h00, stamp});
    end
    {aret, mask, ant, antl} = 4'h4;
    phr = 1'h1;
    fend = 1'h1;
    cyc(1);
    phr = 1'h0;
    fend = 1'h0;
    cyc(1);
    chk("stamp set wins", 8'h01, {7'h00, stamp});
    pulse(fend);
    cyc(1);
    chk("stamp cleared", 8'h00, {7'h00, stamp});
    $display("test stamp table done");
    wreg(`RFSB_TRX_CTRL_ONE_ADDR, 8'h80);
    cyc(1);
    chk("pair enabled", 8'h01, {6'h00, pos, neg});
    pulse(txq);
    cyc(600);
    chk("pair before on delay", 8'h01, {6'h00, pos, neg});
    cyc(1);
    chk("pair transmit", 8'h02, {6'h00, pos, neg});
    wreg(`RFSB_TRX_CTRL_ONE_ADDR, 8'h00);
    cyc(1);
    chk("pair disabled in transmit", 8'h00, {6'h00, pos, neg});
    wreg(`RFSB_TRX_CTRL_ONE_ADDR, 8'h80);
    cyc(1);
    pulse(paoff);
    cyc(300);
    chk("pair before off delay", 8'h02, {6'h00, pos, neg});
    cyc(1);
    chk("pair receive", 8'h01, {6'h00, pos, neg});
    $display("test front end done");
    wreg(`RFSB_TRX_CTRL_ONE_ADDR, 8'h10);
    read_go(8'h01, 8'h02, 1'h0);
    cyc(20);
    chk("bytes before pause", 8'h01, got);
    chk("indicator empty", 8'h01, {7'h00, irq});
    cnt = 8'h02;
    wait_for(busy, 1'h0, "read end");
    chk("bytes read", 8'h02, got);
    cyc(3);
    chk("interrupt after read", 8'h00, {7'h00, irq});
    cirq = 1'h1;
    read_go(8'h05, 8'h01, 1'h1);
    cyc(10);
    chk("indicator hides interrupt", 8'h00, {7'h00, irq});
    pulse(rxe);
    cyc(6);
    chk("indicator locked", 8'h01, {7'h00, irq});
    cirq = 1'h0;
    hold = 1'h0;
    wait_for(busy, 1'h0, "read end");
    cyc(3);
    chk("lock released", 8'h00, {7'h00, irq});
    wreg(`RFSB_TRX_CTRL_ONE_ADDR, 8'h00);
    read_go(8'h00, 8'h00, 1'h1);
    cyc(5);
    chk("indicator disabled", 8'h00, {7'h00, irq});
    hold = 1'h0;
    wait_for(busy, 1'h0, "read end");
    $display("test buffer indicator done");
    finish_test;
  end
endmodule // tb
